/* File: hw/gpe_top.sv */
`timescale 1ns/100ps
`include "gpe_map.svh"

module gpe_top #(
    parameter int ADDR_W  = 7,
    parameter int N_PORTS = 4,
    parameter int N_DIR   = 2,
    parameter int N_SRC   = 16
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   pfail_rst_i,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    input  wire logic [N_PORTS*8-1:0]   pin_in_i,
    output logic [N_PORTS*8-1:0]        pin_out_o,
    output logic [N_PORTS*8-1:0]        pin_oe_n_o,
    output logic [N_PORTS*8-1:0]        pullup_en_o,
    input  wire logic [N_SRC-1:0]       irq_pin_i,
    output logic                        irq_o
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    gpe_pkg::gpe_byte_type out_data_r [N_PORTS];
    gpe_pkg::gpe_byte_type dir_r      [N_DIR];
    gpe_pkg::gpe_src_type  flag_r;
    gpe_pkg::gpe_src_type  flag_nxt;
    gpe_pkg::gpe_src_type  en_r;
    gpe_pkg::gpe_src_type  es_r;
    gpe_pkg::gpe_src_type  clr_mask;
    gpe_pkg::gpe_src_type  sync1_r;
    gpe_pkg::gpe_src_type  sync2_r;
    gpe_pkg::gpe_src_type  prev_r;
    gpe_pkg::gpe_src_type  edge_hit;

    logic                  any_rst;
    logic                  aw_got_r;
    logic                  w_got_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  rvalid_r;
    logic [1:0]            rresp_r;
    logic [31:0]           rdata_r;
    gpe_pkg::gpe_idx_type  aw_idx_r;
    gpe_pkg::gpe_byte_type wbyte_r;
    logic                  wlane_r;
    logic                  wr_do;
    logic                  wr_en;
    logic                  ar_fire;
    gpe_pkg::gpe_idx_type  ar_idx;

    assign any_rst = rst_i | pfail_rst_i;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic gpe_pkg::gpe_idx_type to_idx(input logic [ADDR_W-1:0] a);
        to_idx = a[`GPE_IDX_LSB +: 5];
    endfunction

    function automatic logic is_mapped(input gpe_pkg::gpe_idx_type i);
        if (i <= `GPE_IDX_ESH) begin
            is_mapped = 1'b1;
        end else if (i == `GPE_IDX_DIR0 || i == `GPE_IDX_DIR1) begin
            is_mapped = 1'b1;
        end else if (i == `GPE_IDX_CLRL || i == `GPE_IDX_CLRH) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    assign s_axi_awready_o = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready_o  = ~w_got_r & ~bvalid_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign wr_do           = aw_got_r & w_got_r;
    assign wr_en           = wr_do & wlane_r & is_mapped(aw_idx_r);

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            aw_got_r <= 1'b0;
            aw_idx_r <= 5'h00;
        end else if (wr_do) begin
            aw_got_r <= 1'b0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= to_idx(s_axi_awaddr_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            w_got_r <= 1'b0;
            wbyte_r <= `GPE_RST_BYTE;
            wlane_r <= 1'b0;
        end else if (wr_do) begin
            w_got_r <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_r <= 1'b1;
            wbyte_r <= s_axi_wdata_i[7:0];
            wlane_r <= s_axi_wstrb_i[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `GPE_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= is_mapped(aw_idx_r) ? `GPE_RESP_OKAY : `GPE_RESP_SLV;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign s_axi_arready_o = ~rvalid_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rdata_o   = rdata_r;
    assign ar_fire         = s_axi_arvalid_i & ~rvalid_r;
    assign ar_idx          = to_idx(s_axi_araddr_i);

    function automatic gpe_pkg::gpe_byte_type rd_byte(input gpe_pkg::gpe_idx_type i);
        if (i == `GPE_IDX_OUT0) begin
            rd_byte = out_data_r[0];
        end else if (i == `GPE_IDX_OUT1) begin
            rd_byte = out_data_r[1];
        end else if (i == `GPE_IDX_OUT2) begin
            rd_byte = out_data_r[2];
        end else if (i == `GPE_IDX_OUT3) begin
            rd_byte = out_data_r[3];
        end else if (i == `GPE_IDX_FLGL) begin
            rd_byte = flag_r[7:0];
        end else if (i == `GPE_IDX_ENL) begin
            rd_byte = en_r[7:0];
        end else if (i == `GPE_IDX_FLGH) begin
            rd_byte = flag_r[15:8];
        end else if (i == `GPE_IDX_ENH) begin
            rd_byte = en_r[15:8];
        end else if (i == `GPE_IDX_PIN0) begin
            rd_byte = pin_in_i[7:0];
        end else if (i == `GPE_IDX_PIN1) begin
            rd_byte = pin_in_i[15:8];
        end else if (i == `GPE_IDX_PIN2) begin
            rd_byte = pin_in_i[23:16];
        end else if (i == `GPE_IDX_PIN3) begin
            rd_byte = pin_in_i[31:24];
        end else if (i == `GPE_IDX_ESL) begin
            rd_byte = es_r[7:0];
        end else if (i == `GPE_IDX_ESH) begin
            rd_byte = es_r[15:8];
        end else if (i == `GPE_IDX_DIR0) begin
            rd_byte = dir_r[0];
        end else if (i == `GPE_IDX_DIR1) begin
            rd_byte = dir_r[1];
        end else begin
            rd_byte = `GPE_RST_BYTE;
        end
    endfunction

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `GPE_RESP_OKAY;
            rdata_r  <= 32'h00000000;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= is_mapped(ar_idx) ? `GPE_RESP_OKAY : `GPE_RESP_SLV;
            rdata_r  <= {24'h000000, rd_byte(ar_idx)}; // R07 R01
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // port registers and pins
    // ----------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < N_PORTS; gp++) begin : g_port
            gpe_pkg::gpe_byte_type dir_eff;
            always_ff @(posedge clk_i) begin
                if (any_rst) begin
                    out_data_r[gp] <= `GPE_RST_BYTE; // R01
                end else if (wr_en && aw_idx_r == `GPE_IDX_OUT0 + 5'(gp)) begin
                    out_data_r[gp] <= wbyte_r; // R01 R03
                end
            end
            if (gp < N_DIR) begin : g_dir
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        dir_r[gp] <= `GPE_RST_BYTE; // R06
                    end else if (pfail_rst_i) begin
                        dir_r[gp] <= dir_r[gp]; // R06
                    end else if (wr_en && aw_idx_r == `GPE_IDX_DIR0 + 5'(gp)) begin
                        dir_r[gp] <= wbyte_r; // R05
                    end
                end
                assign dir_eff = dir_r[gp];
            end else begin : g_in_only
                assign dir_eff = `GPE_RST_BYTE;
            end
            assign pin_out_o[gp*8 +: 8]   = out_data_r[gp]; // R02
            assign pin_oe_n_o[gp*8 +: 8]  = ~dir_eff; // R05
            assign pullup_en_o[gp*8 +: 8] = out_data_r[gp] & ~dir_eff; // R04 R02
        end
    endgenerate

    // ----------------------------------------
    // interrupt sources
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            sync1_r <= `GPE_RST_16;
            sync2_r <= `GPE_RST_16;
            prev_r  <= `GPE_RST_16;
        end else begin
            sync1_r <= irq_pin_i; // R16
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // 0 rising, 1 falling
    assign edge_hit = (~es_r & sync2_r & ~prev_r) | (es_r & ~sync2_r & prev_r); // R08 R16

    always_comb begin
        clr_mask = `GPE_RST_16;
        if (wr_en && aw_idx_r == `GPE_IDX_CLRL) begin
            clr_mask[7:0] = wbyte_r;
        end else if (wr_en && aw_idx_r == `GPE_IDX_CLRH) begin
            clr_mask[15:8] = wbyte_r;
        end
        flag_nxt = flag_r & ~clr_mask; // R11
        if (wr_en && aw_idx_r == `GPE_IDX_FLGL) begin
            flag_nxt[7:0] = wbyte_r; // R14
        end else if (wr_en && aw_idx_r == `GPE_IDX_FLGH) begin
            flag_nxt[15:8] = wbyte_r;
        end
        flag_nxt = flag_nxt | edge_hit; // R09
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            flag_r <= `GPE_RST_16; // R14
        end else begin
            flag_r <= flag_nxt; // R11
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            en_r <= `GPE_RST_16; // R14
            es_r <= `GPE_RST_16;
        end else if (wr_en) begin
            if (aw_idx_r == `GPE_IDX_ENL) begin
                en_r[7:0] <= wbyte_r; // R13
            end else if (aw_idx_r == `GPE_IDX_ENH) begin
                en_r[15:8] <= wbyte_r; // R13
            end else if (aw_idx_r == `GPE_IDX_ESL) begin
                es_r[7:0] <= wbyte_r; // R08
            end else if (aw_idx_r == `GPE_IDX_ESH) begin
                es_r[15:8] <= wbyte_r; // R08
            end
        end
    end

    assign irq_o = |(flag_r & en_r); // R10

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (any_rst);

    logic wr_flg_lo;
    logic wr_dir0;
    assign wr_flg_lo = wr_en && (aw_idx_r == `GPE_IDX_FLGL || aw_idx_r == `GPE_IDX_CLRL);
    assign wr_dir0   = wr_en && aw_idx_r == `GPE_IDX_DIR0;

    property p_out_reset;
        disable iff (1'b0) rst_i |=> out_data_r[0] == 8'h00 && out_data_r[3] == 8'h00;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("port data not cleared"); // R01

    property p_dir_keep;
        disable iff (rst_i) pfail_rst_i |=> dir_r[0] == $past(dir_r[0]) && dir_r[1] == $past(dir_r[1]);
    endproperty
    a_dir_keep: assert property (p_dir_keep) else $error("direction lost on power-fail"); // R06

    property p_dir_clear;
        disable iff (1'b0) rst_i |=> dir_r[0] == 8'h00 && pin_oe_n_o[7:0] == 8'hFF;
    endproperty
    a_dir_clear: assert property (p_dir_clear) else $error("direction not cleared"); // R06

    property p_dir_write;
        wr_dir0 |=> (pin_oe_n_o[7:0] == ~$past(wbyte_r)) && $stable(out_data_r[0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write wrong"); // R03

    property p_pullup;
        (!pin_oe_n_o[0] |-> !pullup_en_o[0]) and
            (pin_oe_n_o[0] |-> pullup_en_o[0] == pin_out_o[0]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on while driving"); // R04

    property p_rise_sets;
        !es_r[0] && !prev_r[0] && sync2_r[0] && !wr_flg_lo |=> flag_r[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed"); // R09

    property p_pin_to_flag;
        !es_r[1] ##1 (!irq_pin_i[1] && !es_r[1]) [*3] ##1 (irq_pin_i[1] && !es_r[1]) [*3]
            ##0 !wr_flg_lo [*2] |=> flag_r[1];
    endproperty
    a_pin_to_flag: assert property (p_pin_to_flag) else $error("synchronised edge missed"); // R16

    property p_sticky;
        flag_r[0] && !wr_flg_lo |=> flag_r[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped by itself"); // R11

    property p_irq_level;
        flag_r[4] && en_r[4] |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("request missing"); // R10

    property p_disable;
        (flag_r & en_r) == 16'h0000 |-> !irq_o;
    endproperty
    a_disable: assert property (p_disable) else $error("request without enabled flag"); // R13

    property p_pin_read;
        ar_fire && ar_idx == `GPE_IDX_PIN0 |=> rdata_r[7:0] == $past(pin_in_i[7:0]) && rvalid_r;
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level read wrong"); // R07

    property p_flag_reset;
        disable iff (1'b0) any_rst |=> flag_r == 16'h0000 && en_r == 16'h0000 && es_r == 16'h0000;
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("irq regs not cleared"); // R14

    c_edge_flag: cover property (edge_hit[0] ##1 flag_r[0]);
    c_irq_rise:  cover property (!irq_o ##1 irq_o);
    c_pfail:     cover property (dir_r[0] != 8'h00 ##1 pfail_rst_i ##1 dir_r[0] != 8'h00);
    c_read:      cover property (ar_fire ##1 rvalid_r && s_axi_rready_i);

endmodule

/* File: include/gpe_map.svh */
// What this block does
// R01: port output data bytes reset to zero on any reset and read back unchanged.
// R02: output pins drive their data bit; input pins use it for pull-up.
// R03: direction writes never disturb a port's output data byte.
// R04: on an input pin, data 1 enables pull-up, data 0 leaves three-state.
// R05: each direction bit sets its pin: 1 drives output, 0 is input.
// R06: direction clears on system reset (rst_i) but is kept through power-fail reset.
// R07: pin level registers are read-only and show the live pin levels.
// R08: edge-select 0 means rising edge, 1 means falling edge, per source.
// R09: hardware sets a source flag when its selected edge is seen.
// R10: any set flag with its enable set raises the interrupt request.
// R11: a flag stays set until software clears it or reset occurs.
// R12: software clears the flag before leaving its handler.
// R13: enable bit 1 enables a source, 0 disables its request.
// R14: flag, enable and edge-select bytes are read/write, reset to zero.
// R15: without upper pins, software avoids writing the upper flag byte.
// R16: interrupt pins are synchronised; each qualifying edge sets its flag once.
`ifndef GPE_MAP_SVH
`define GPE_MAP_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define GPE_IDX_OUT0   5'h00
`define GPE_IDX_OUT1   5'h01
`define GPE_IDX_OUT2   5'h02
`define GPE_IDX_OUT3   5'h03
`define GPE_IDX_FLGL   5'h04
`define GPE_IDX_ENL    5'h05
`define GPE_IDX_FLGH   5'h06
`define GPE_IDX_ENH    5'h07
`define GPE_IDX_PIN0   5'h08
`define GPE_IDX_PIN1   5'h09
`define GPE_IDX_PIN2   5'h0A
`define GPE_IDX_PIN3   5'h0B
`define GPE_IDX_ESL    5'h0C
`define GPE_IDX_ESH    5'h0D
`define GPE_IDX_DIR0   5'h10
`define GPE_IDX_DIR1   5'h11
`define GPE_IDX_CLRL   5'h14
`define GPE_IDX_CLRH   5'h15

// ----------------------------------------
// reset values, bus answers and index bit position
// ----------------------------------------
`define GPE_RST_BYTE   8'h00
`define GPE_RST_16     16'h0000
`define GPE_RESP_OKAY  2'h0
`define GPE_RESP_SLV   2'h2
`define GPE_IDX_LSB    2

`endif

/* File: include/gpe_pkg.sv */
package gpe_pkg;
    typedef logic [7:0]  gpe_byte_type;
    typedef logic [15:0] gpe_src_type;
    typedef logic [4:0]  gpe_idx_type;
endpackage

/* File: testbench/gpe_board.sv */
`timescale 1ns/100ps

// ----------------------------------------
// board side of the port pins
// ----------------------------------------
module gpe_board (
    input  wire logic        clk_i,
    input  wire logic [31:0] pin_out_i,
    input  wire logic [31:0] pin_oe_n_i,
    input  wire logic [31:0] pullup_en_i,
    input  wire logic [31:0] drv_en_i,
    input  wire logic [31:0] drv_val_i,
    output logic      [31:0] level_o
);
    logic [31:0] float_r = 32'h0000_0000;

    // undriven unpulled pins wander every cycle
    always_ff @(posedge clk_i) begin
        float_r <= ~level_o;
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!pin_oe_n_i[i]) begin
                level_o[i] = pin_out_i[i];
            end else if (drv_en_i[i]) begin
                level_o[i] = drv_val_i[i];
            end else if (pullup_en_i[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = float_r[i];
            end
        end
    end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "gpe_map.svh"

module tb_top;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        pfail_rst_i = 1'b0;
    logic [6:0]  aw_addr     = 7'h00;
    logic        aw_valid    = 1'b0;
    logic [31:0] w_data      = 32'h0000_0000;
    logic [3:0]  w_strb      = 4'h1;
    logic        w_valid     = 1'b0;
    logic        b_ready     = 1'b1;
    logic [6:0]  ar_addr     = 7'h00;
    logic        ar_valid    = 1'b0;
    logic        r_ready     = 1'b1;
    logic [31:0] drv_en      = 32'hFFFF_FFFF;
    logic [31:0] drv_val     = 32'h5A3C_E719;
    logic [15:0] irq_pins    = 16'h0000;
    logic [31:0] lfsr_r      = 32'hFFC6AD7A;
    logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, irq;
    logic [1:0]  b_resp, r_resp;
    logic [31:0] r_data, pin_out, pin_oe_n, pullup_en, pin_lvl;
    logic [1:0]  wq [$];
    logic [33:0] rq [$];
    int          bad_count   = 0;
    int          check_count = 0;
    logic [4:0]  rw_idx [12] = '{`GPE_IDX_OUT0, `GPE_IDX_OUT1, `GPE_IDX_OUT2, `GPE_IDX_OUT3, `GPE_IDX_FLGL,
        `GPE_IDX_ENL, `GPE_IDX_FLGH, `GPE_IDX_ENH, `GPE_IDX_ESL, `GPE_IDX_ESH, `GPE_IDX_DIR0, `GPE_IDX_DIR1};

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    gpe_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .pfail_rst_i(pfail_rst_i),
        .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
        .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
        .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
        .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
        .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pullup_en_o(pullup_en),
        .irq_pin_i(irq_pins), .irq_o(irq));

    gpe_board board_u (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n), .pullup_en_i(pullup_en),
        .drv_en_i(drv_en), .drv_val_i(drv_val), .level_o(pin_lvl));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // oldest note is compared whenever a response is taken
    always @(posedge clk_i) begin
        if (b_valid === 1'b1 && b_ready && wq.size() > 0) chk("bresp", {32'h0, b_resp}, {32'h0, wq.pop_front()});
        if (r_valid === 1'b1 && r_ready && rq.size() > 0) chk("rdata", {r_resp, r_data}, rq.pop_front());
    end

    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        int n;
        n = 0;
        wq.push_back(rsp);
        aw_addr  <= {idx, 2'b00};
        w_data   <= {24'h00_0000, d};
        aw_valid <= 1'b1;
        w_valid  <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
        end while (b_valid !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic rd(input logic [4:0] idx, input logic [1:0] rsp, input logic [7:0] d);
        int n;
        n = 0;
        rq.push_back({rsp, 24'h00_0000, d});
        ar_addr  <= {idx, 2'b00};
        ar_valid <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        chk("irq", {33'h0, irq}, {33'h0, exp});
    endtask

    task automatic do_reset(input logic pf);
        if (pf) pfail_rst_i <= 1'b1;
        else rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i       <= 1'b0;
        pfail_rst_i <= 1'b0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v [12];
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rw_idx[i]) rd(rw_idx[i], `GPE_RESP_OKAY, `GPE_RST_BYTE);
        for (int p = 0; p < 4; p++) rd(5'(`GPE_IDX_PIN0 + p), `GPE_RESP_OKAY, drv_val[8*p+:8]);
        // random bytes into every stored register, then read back
        foreach (rw_idx[i]) begin
            lfsr_r = lfsr_next(lfsr_r);
            v[i]   = lfsr_r[7:0];
            wr(rw_idx[i], v[i], `GPE_RESP_OKAY);
        end
        foreach (rw_idx[i]) rd(rw_idx[i], `GPE_RESP_OKAY, v[i]);
        wait_irq(|({v[6], v[4]} & {v[7], v[5]}));
        chk("oe_n", {2'h0, pin_oe_n}, {18'h0_FFFF, ~v[11], ~v[10]});
        chk("pullup", {2'h0, pullup_en}, {2'h0, v[3], v[2], v[1] & ~v[11], v[0] & ~v[10]});
        chk("pin_out", {2'h0, pin_out}, {2'h0, v[3], v[2], v[1], v[0]});
        do_reset(1'b0);
        // unmapped place, write-only clear place, disabled strobe
        wr(5'h0E, 8'hFF, `GPE_RESP_SLV);
        rd(5'h0E, `GPE_RESP_SLV, 8'h00);
        rd(`GPE_IDX_CLRL, `GPE_RESP_OKAY, 8'h00);
        w_strb <= 4'h0;
        wr(`GPE_IDX_OUT1, 8'hFF, `GPE_RESP_OKAY);
        w_strb <= 4'h1;
        rd(`GPE_IDX_OUT1, `GPE_RESP_OKAY, 8'h00);
        // mixed directions on port 0
        drv_en[7:0]  <= 8'h0E;
        drv_val[7:0] <= 8'h0A;
        wr(`GPE_IDX_OUT0, 8'hA5, `GPE_RESP_OKAY);
        wr(`GPE_IDX_DIR0, 8'hF0, `GPE_RESP_OKAY);
        chk("oe_n0", {26'h0, pin_oe_n[7:0]}, {26'h0, 8'h0F});
        chk("pullup0", {26'h0, pullup_en[7:0]}, {26'h0, 8'h05});
        chk("out0", {26'h0, pin_out[7:0]}, {26'h0, 8'hA5});
        rd(`GPE_IDX_PIN0, `GPE_RESP_OKAY, 8'hAB);
        wr(`GPE_IDX_DIR0, 8'h00, `GPE_RESP_OKAY);
        rd(`GPE_IDX_OUT0, `GPE_RESP_OKAY, 8'hA5);
        wr(`GPE_IDX_DIR0, 8'hF0, `GPE_RESP_OKAY);
        do_reset(1'b1);
        rd(`GPE_IDX_DIR0, `GPE_RESP_OKAY, 8'hF0);
        rd(`GPE_IDX_OUT0, `GPE_RESP_OKAY, 8'h00);
        do_reset(1'b0);
        rd(`GPE_IDX_DIR0, `GPE_RESP_OKAY, 8'h00);
        // edge interrupts: source 0 rising, source 9 falling
        wr(`GPE_IDX_ESH, 8'h02, `GPE_RESP_OKAY);
        wr(`GPE_IDX_ENL, 8'h01, `GPE_RESP_OKAY);
        irq_pins <= 16'h0201;
        wait_irq(1'b1);
        rd(`GPE_IDX_FLGL, `GPE_RESP_OKAY, 8'h01);
        rd(`GPE_IDX_FLGH, `GPE_RESP_OKAY, 8'h00);
        irq_pins <= 16'h0001;
        repeat (4) @(posedge clk_i);
        rd(`GPE_IDX_FLGH, `GPE_RESP_OKAY, 8'h02);
        irq_pins <= 16'h0000;
        repeat (4) @(posedge clk_i);
        rd(`GPE_IDX_FLGL, `GPE_RESP_OKAY, 8'h01);
        wr(`GPE_IDX_ENL, 8'h00, `GPE_RESP_OKAY);
        wait_irq(1'b0);
        wr(`GPE_IDX_ENH, 8'h02, `GPE_RESP_OKAY);
        wait_irq(1'b1);
        wr(`GPE_IDX_CLRH, 8'h02, `GPE_RESP_OKAY);
        wait_irq(1'b0);
        // held level sets once, cleared flag stays clear
        irq_pins <= 16'h0003;
        repeat (4) @(posedge clk_i);
        rd(`GPE_IDX_FLGL, `GPE_RESP_OKAY, 8'h03);
        wr(`GPE_IDX_CLRL, 8'h03, `GPE_RESP_OKAY);
        repeat (4) @(posedge clk_i);
        rd(`GPE_IDX_FLGL, `GPE_RESP_OKAY, 8'h00);
        // flag written by software
        wr(`GPE_IDX_ENL, 8'h80, `GPE_RESP_OKAY);
        wr(`GPE_IDX_FLGL, 8'h80, `GPE_RESP_OKAY);
        wait_irq(1'b1);
        wr(`GPE_IDX_FLGL, 8'h00, `GPE_RESP_OKAY);
        wait_irq(1'b0);
        // upper enable and edge-select as scratch, upper flag byte never written
        wr(`GPE_IDX_ENH, 8'h5A, `GPE_RESP_OKAY);
        wr(`GPE_IDX_ESH, 8'hA5, `GPE_RESP_OKAY);
        rd(`GPE_IDX_ENH, `GPE_RESP_OKAY, 8'h5A);
        rd(`GPE_IDX_ESH, `GPE_RESP_OKAY, 8'hA5);
        rd(`GPE_IDX_FLGH, `GPE_RESP_OKAY, 8'h00);
        wait_irq(1'b0);
        final_report();
    end
endmodule
